//--- logic/or_ret_pkg.sv
// Shared widths, reset values and operation codes of the OR and return executor.
// Assumes a decoder on the same clock presents one operation at a time.
package or_ret_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned DATA_W = 8;   // Accumulator and data memory byte
  localparam int unsigned ADDR_W = 9;   // Data memory address
  localparam int unsigned PC_W   = 13;  // Program counter

  // ==========================================================================
  // Values after reset
  localparam logic [DATA_W-1:0] ACCUMULATOR_RST             = 8'h00;
  localparam logic              ZERO_FLAG_RST               = 1'b0;
  localparam logic              MASTER_INTERRUPT_ENABLE_RST = 1'b0;
  localparam logic [PC_W-1:0]   PC_RST                      = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST                    = 9'h000;

  // ==========================================================================
  // Operations handed over by the decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_OR_MEM,
    OP_OR_IMM,
    OR_INTO_MEMORY_OP,
    OP_RETURN,
    OP_RETURN_IMM,
    RETURN_FROM_INTERRUPT_OP
  } op_e;

endpackage : or_ret_pkg

//--- logic/or_unit.sv
// Bitwise OR of two bytes with zero detection.
// Assumes both operands are stable in the cycle in which the result is used.
`timescale 1ns/10ps
module or_unit
  import or_ret_pkg::*;
(
  // Operands
  input  wire logic [or_ret_pkg::DATA_W-1:0] a_i,
  input  wire logic [or_ret_pkg::DATA_W-1:0] b_i,
  // Result
  output logic      [or_ret_pkg::DATA_W-1:0] result_o,
  output logic                               zero_o
);

  // ==========================================================================
  // Combine and test
  always_comb
  begin
    result_o = a_i | b_i;
    zero_o   = (result_o == '0);
  end

endmodule : or_unit

//--- logic/or_ret_exec.sv
// Executor for the OR group and the three returns of a small 8-bit core.
// Assumes a same-clock decoder, a data memory answering one cycle after a read,
// a return stack whose top entry is readable while it is popped, and a fetch
// unit that lets an interrupt take precedence over a program counter load.
`timescale 1ns/10ps

// Summary of operation
// - OR memory into accumulator, zero only
// - OR immediate into accumulator, zero only
// - OR result to memory, accumulator kept
// - Return pops program counter, flags kept
// - Return pops counter, loads immediate into accumulator
// - Interrupt return pops counter, sets enable
// - Enabled pending interrupt served before main program
module or_ret_exec
  import or_ret_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  // Operation from the decoder
  input  wire logic                          op_valid_i,
  input  wire or_ret_pkg::op_e               op_i,
  input  wire logic [or_ret_pkg::DATA_W-1:0] imm_i,
  input  wire logic [or_ret_pkg::ADDR_W-1:0] mem_addr_i,
  output logic                               op_ready_o,
  output logic                               op_done_o,
  // Data memory
  output logic                               mem_rd_o,
  output logic                               mem_wr_o,
  output logic      [or_ret_pkg::ADDR_W-1:0] mem_addr_o,
  output logic      [or_ret_pkg::DATA_W-1:0] mem_wdata_o,
  input  wire logic [or_ret_pkg::DATA_W-1:0] mem_rdata_i,
  // Return stack
  output logic                               stack_pop_o,
  input  wire logic [or_ret_pkg::PC_W-1:0]   stack_top_i,
  // Program counter load
  output logic                               pc_load_o,
  output logic      [or_ret_pkg::PC_W-1:0]   pc_o,
  // Interrupt hand-off
  input  wire logic                          irq_pending_i,
  output logic                               irq_take_o,
  // Core state
  output logic      [or_ret_pkg::DATA_W-1:0] accumulator_o,
  output logic                               zero_flag_o,
  output logic                               master_interrupt_enable_o
);

  import or_ret_pkg::*;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_WRITE,
    ST_IRQ
  } state_e;

  state_e              state_q;
  state_e              state_d;
  op_e                 op_q;
  op_e                 op_d;
  logic [DATA_W-1:0]   accumulator_q;
  logic [DATA_W-1:0]   accumulator_d;
  logic                zero_q;
  logic                zero_d;
  logic                master_interrupt_enable_q;
  logic                master_interrupt_enable_d;
  logic [ADDR_W-1:0]   addr_q;
  logic [ADDR_W-1:0]   addr_d;
  logic [DATA_W-1:0]   result_q;
  logic [DATA_W-1:0]   result_d;
  logic [PC_W-1:0]     pc_q;
  logic [PC_W-1:0]     pc_d;
  logic                pc_load_q;
  logic                pc_load_d;
  logic                done_q;
  logic                done_d;

  // ==========================================================================
  // OR datapath
  logic [DATA_W-1:0]   or_operand;
  logic [DATA_W-1:0]   or_result;
  logic                or_zero;
  logic                irq_ready;

  // Second operand is the immediate while idle, the memory byte otherwise
  always_comb
  begin
    or_operand = (state_q == ST_IDLE) ? imm_i : mem_rdata_i;
  end

  or_unit u_or_unit (
    .a_i      (accumulator_q),
    .b_i      (or_operand),
    .result_o (or_result),
    .zero_o   (or_zero)
  );

  // ==========================================================================
  // Handshake outputs
  always_comb
  begin
    irq_ready   = master_interrupt_enable_q & irq_pending_i;
    op_ready_o  = (state_q == ST_IDLE) & ~irq_ready;
    mem_rd_o    = (state_q == ST_READ);
    mem_wr_o    = (state_q == ST_WRITE);
    irq_take_o  = (state_q == ST_IRQ);
    stack_pop_o = op_ready_o & op_valid_i &
                  ((op_i == OP_RETURN) | (op_i == OP_RETURN_IMM) | (op_i == RETURN_FROM_INTERRUPT_OP));
  end

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    state_d                   = state_q;
    op_d                      = op_q;
    accumulator_d             = accumulator_q;
    zero_d                    = zero_q;
    master_interrupt_enable_d = master_interrupt_enable_q;
    addr_d                    = addr_q;
    result_d                  = result_q;
    pc_d                      = pc_q;
    pc_load_d                 = 1'b0;
    done_d                    = 1'b0;

    unique case (state_q)
      ST_IDLE:
      begin
        if (irq_ready)
        begin
          // Enabled pending interrupt goes ahead of any new operation
          state_d = ST_IRQ;
        end
        else if (op_valid_i)
        begin
          op_d   = op_i;
          addr_d = mem_addr_i;
          unique case (op_i)
            OP_OR_MEM,
            OR_INTO_MEMORY_OP:
            begin
              // Fetch the memory operand first
              state_d = ST_READ;
            end
            OP_OR_IMM:
            begin
              accumulator_d = or_result;
              zero_d        = or_zero;
              done_d        = 1'b1;
            end
            OP_RETURN:
            begin
              pc_d      = stack_top_i;
              pc_load_d = 1'b1;
              done_d    = 1'b1;
            end
            OP_RETURN_IMM:
            begin
              pc_d          = stack_top_i;
              pc_load_d     = 1'b1;
              accumulator_d = imm_i;
              done_d        = 1'b1;
            end
            RETURN_FROM_INTERRUPT_OP:
            begin
              pc_d                      = stack_top_i;
              pc_load_d                 = 1'b1;
              master_interrupt_enable_d = 1'b1;
              done_d                    = 1'b1;
              if (irq_pending_i)
              begin
                // Vector out before the restored address is executed
                state_d = ST_IRQ;
              end
            end
            OP_NONE:
            begin
              done_d = 1'b1;
            end
            default:
            begin
              // Unused code acts as no operation
              done_d = 1'b1;
            end
          endcase
        end
      end

      ST_READ:
      begin
        // Memory answers in the next cycle
        state_d = ST_EXEC;
      end

      ST_EXEC:
      begin
        zero_d = or_zero;
        if (op_q == OR_INTO_MEMORY_OP)
        begin
          result_d = or_result;
          state_d  = ST_WRITE;
        end
        else
        begin
          accumulator_d = or_result;
          done_d        = 1'b1;
          state_d       = ST_IDLE;
        end
      end

      ST_WRITE:
      begin
        // Byte goes back to the same address, accumulator untouched
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end

      ST_IRQ:
      begin
        // Taking the interrupt masks further ones
        master_interrupt_enable_d = 1'b0;
        state_d                   = ST_IDLE;
      end

      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_q                   <= ST_IDLE;
      op_q                      <= OP_NONE;
      accumulator_q             <= ACCUMULATOR_RST;
      zero_q                    <= ZERO_FLAG_RST;
      master_interrupt_enable_q <= MASTER_INTERRUPT_ENABLE_RST;
      addr_q                    <= ADDR_RST;
      result_q                  <= ACCUMULATOR_RST;
      pc_q                      <= PC_RST;
      pc_load_q                 <= 1'b0;
      done_q                    <= 1'b0;
    end
    else
    begin
      state_q                   <= state_d;
      op_q                      <= op_d;
      accumulator_q             <= accumulator_d;
      zero_q                    <= zero_d;
      master_interrupt_enable_q <= master_interrupt_enable_d;
      addr_q                    <= addr_d;
      result_q                  <= result_d;
      pc_q                      <= pc_d;
      pc_load_q                 <= pc_load_d;
      done_q                    <= done_d;
    end
  end

  // ==========================================================================
  // Registered outputs
  always_comb
  begin
    op_done_o                 = done_q;
    mem_addr_o                = addr_q;
    mem_wdata_o               = result_q;
    pc_load_o                 = pc_load_q;
    pc_o                      = pc_q;
    accumulator_o             = accumulator_q;
    zero_flag_o               = zero_q;
    master_interrupt_enable_o = master_interrupt_enable_q;
  end

endmodule : or_ret_exec

//--- verification/or_ret_chk.sv
// Checker for the OR and return executor, bound to its top ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
module or_ret_chk
  import or_ret_pkg::*;
(
  // Requests and returned data
  input wire logic            clk_i,
  input wire logic            nrst_i,
  input wire logic            op_valid_i,
  input wire or_ret_pkg::op_e op_i,
  input wire logic [7:0]      imm_i,
  input wire logic [8:0]      mem_addr_i,
  input wire logic [7:0]      mem_rdata_i,
  input wire logic [12:0]     stack_top_i,
  input wire logic            irq_pending_i,
  // Outputs watched
  input wire logic            op_ready_o,
  input wire logic            op_done_o,
  input wire logic            mem_rd_o,
  input wire logic            mem_wr_o,
  input wire logic [8:0]      mem_addr_o,
  input wire logic [7:0]      mem_wdata_o,
  input wire logic            stack_pop_o,
  input wire logic            pc_load_o,
  input wire logic [12:0]     pc_o,
  input wire logic            irq_take_o,
  input wire logic [7:0]      accumulator_o,
  input wire logic            zero_flag_o,
  input wire logic            master_interrupt_enable_o
);
  // ==========================================================================
  // Accept strobe and defaults
  logic tk;
  assign tk = op_valid_i && op_ready_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================================
  // Properties
  chk_imm_result: assert property (
    tk && op_i == OP_OR_IMM |=> op_done_o && accumulator_o == ($past(accumulator_o) | $past(imm_i)))
    else $error("or immediate result wrong");
  chk_or_zero: assert property (
    tk && op_i == OP_OR_IMM |=> zero_flag_o == (accumulator_o == 8'h00))
    else $error("zero flag does not follow or result");
  chk_mem_read: assert property (
    tk && op_i == OP_OR_MEM |=> mem_rd_o && mem_addr_o == $past(mem_addr_i))
    else $error("memory read not issued");
  chk_mem_result: assert property (
    tk && op_i == OP_OR_MEM |-> ##3 op_done_o && accumulator_o == ($past(accumulator_o, 3) | $past(mem_rdata_i)))
    else $error("or memory result wrong");
  chk_or_writeback: assert property (
    tk && op_i == OR_INTO_MEMORY_OP |-> ##3 mem_wr_o && $stable(accumulator_o) && mem_wdata_o == (accumulator_o | $past(mem_rdata_i)))
    else $error("or to memory write wrong");
  chk_ret_pop: assert property (
    tk && op_i inside {OP_RETURN, OP_RETURN_IMM, RETURN_FROM_INTERRUPT_OP} |-> stack_pop_o ##1 pc_load_o && pc_o == $past(stack_top_i) && $stable(zero_flag_o))
    else $error("return did not load popped address");
  chk_retimm_load: assert property (
    tk && op_i == OP_RETURN_IMM |=> accumulator_o == $past(imm_i))
    else $error("return immediate not loaded");
  chk_intret_enable: assert property (
    tk && op_i == RETURN_FROM_INTERRUPT_OP |=> master_interrupt_enable_o)
    else $error("interrupt enable not set");
  chk_intret_irq: assert property (
    tk && op_i == RETURN_FROM_INTERRUPT_OP && irq_pending_i |=> irq_take_o && !op_ready_o)
    else $error("pending interrupt not taken");
endmodule : or_ret_chk

bind or_ret_exec or_ret_chk i_or_ret_chk (.*);

//--- verification/or_ret_exec_tb_top.sv
// Testbench for the OR and return executor.
// Assumes the bench plays decoder, memory and stack, driving at the falling edge.
`timescale 1ns/10ps
module or_ret_exec_tb_top;
  import or_ret_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0, irq_pending_i = 1'b0;
  op_e         op_i = OP_NONE;
  logic [7:0]  imm_i = 8'h00, mem_rdata_i = 8'h00, mem_wdata_o, accumulator_o;
  logic [8:0]  mem_addr_i = 9'h000, mem_addr_o;
  logic [12:0] stack_top_i = 13'h0000, pc_o;
  logic        op_ready_o, op_done_o, mem_rd_o, mem_wr_o, stack_pop_o, pc_load_o;
  logic        irq_take_o, zero_flag_o, master_interrupt_enable_o;
  int          mismatches = 0, n_compared = 0;
  logic [7:0]  mem_byte = 8'h00;
  logic        rd_seen = 1'b0;

  // Clock and device
  always #2 clk_i = ~clk_i;
  or_ret_exec i_or_ret_exec (.*);

  // Memory answers in the cycle after a read strobe and shows zero otherwise,
  // so a byte taken in the wrong cycle is caught
  always @(negedge clk_i)
  begin
    mem_rdata_i <= rd_seen ? mem_byte : 8'h00;
    rd_seen     <= mem_rd_o;
  end

  // ==========================================================================
  // Shared tasks
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // Let one edge pass after the previous offer, offer one operation, count cycles to done
  task automatic run(op_e o, logic [7:0] im, logic [8:0] a, int lat);
    int n;
    @(negedge clk_i);
    op_i = o;
    imm_i = im;
    mem_addr_i = a;
    op_valid_i = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    op_valid_i = 1'b0;
    n = 1;
    while (op_done_o !== 1'b1 && n < 8)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("latency", lat, n);
    if (n == 8)
      wrap_up();
  endtask : run

  // ==========================================================================
  // Scenarios
  task automatic t_or_imm;
    run(OP_OR_IMM, 8'h00, 9'h000, 1);
    chk("zero", 1'b1, zero_flag_o);
    run(OP_OR_IMM, 8'h5A, 9'h000, 1);
    chk("zero", 1'b0, zero_flag_o);
    run(OP_OR_IMM, 8'h81, 9'h000, 1);
    chk("accumulator", 8'hDB, accumulator_o);
  endtask : t_or_imm

  task automatic t_or_mem;
    mem_byte = 8'h24;
    run(OP_OR_MEM, 8'h00, 9'h1A5, 3);
    chk("accumulator", 8'hFF, accumulator_o);
    chk("zero", 1'b0, zero_flag_o);
    chk("address", 9'h1A5, mem_addr_o);
  endtask : t_or_mem

  task automatic t_ret;
    stack_top_i = 13'h0123;
    run(OP_RETURN_IMM, 8'h00, 9'h000, 1);
    chk("accumulator", 8'h00, accumulator_o);
    chk("zero", 1'b0, zero_flag_o);
    chk("pc", 13'h0123, pc_o);
    run(OP_OR_IMM, 8'h00, 9'h000, 1);
    stack_top_i = 13'h1ABC;
    run(OP_RETURN, 8'h00, 9'h000, 1);
    chk("pc", 13'h1ABC, pc_o);
    chk("zero", 1'b1, zero_flag_o);
  endtask : t_ret

  task automatic t_or_to_mem;
    run(OP_RETURN_IMM, 8'h0C, 9'h000, 1);
    mem_byte = 8'h30;
    run(OR_INTO_MEMORY_OP, 8'h00, 9'h0F0, 4);
    chk("write data", 8'h3C, mem_wdata_o);
    chk("address", 9'h0F0, mem_addr_o);
    chk("accumulator", 8'h0C, accumulator_o);
    chk("zero", 1'b0, zero_flag_o);
  endtask : t_or_to_mem

  task automatic t_int_return;
    run(RETURN_FROM_INTERRUPT_OP, 8'h00, 9'h000, 1);
    chk("enable", 1'b1, master_interrupt_enable_o);
    chk("take", 1'b0, irq_take_o);
    irq_pending_i = 1'b1;
    #1;
    chk("ready", 1'b0, op_ready_o);
    @(negedge clk_i);
    chk("take", 1'b1, irq_take_o);
    @(negedge clk_i);
    chk("enable", 1'b0, master_interrupt_enable_o);
    run(RETURN_FROM_INTERRUPT_OP, 8'h00, 9'h000, 1);
    chk("enable", 1'b1, master_interrupt_enable_o);
    chk("take", 1'b1, irq_take_o);
    chk("ready", 1'b0, op_ready_o);
    irq_pending_i = 1'b0;
    @(negedge clk_i);
    chk("enable", 1'b0, master_interrupt_enable_o);
  endtask : t_int_return

  // Reset in mid-run restores the idle state, and the first offer after it is taken
  task automatic t_reset;
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("accumulator", 8'h00, accumulator_o);
    chk("enable", 1'b0, master_interrupt_enable_o);
    chk("pc", 13'h0000, pc_o);
    chk("ready", 1'b1, op_ready_o);
    nrst_i = 1'b1;
    run(OP_OR_IMM, 8'h11, 9'h000, 1);
    chk("accumulator", 8'h11, accumulator_o);
    chk("zero", 1'b0, zero_flag_o);
  endtask : t_reset

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (5) @(negedge clk_i);
    chk("accumulator", 8'h00, accumulator_o);
    chk("ready", 1'b1, op_ready_o);
    nrst_i = 1'b1;
    t_or_imm();
    t_or_mem();
    t_ret();
    t_or_to_mem();
    t_int_return();
    t_reset();
    wrap_up();
  end
endmodule : or_ret_exec_tb_top
